// ### tx_overhead_serial_in_ctrl.sv
// transmit section overhead control: register bank, source selection and K2/M1/B1/B2 shaping
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module tx_overhead_serial_in_ctrl (
  input wire logic clk_sys,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame and slot timing
  input wire logic frame_start,
  input wire logic slot_valid,
  input wire logic [3:0] slot_id,
  // byte sources
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] parity_byte,
  input wire logic [7:0] ms_err_count,
  input wire logic excess_ms_error_state,
  input wire logic [7:0] tx_overhead_serial_in,
  input wire logic [7:0] tx_rs_orderwire_in,
  input wire logic [7:0] tx_user_channel_in,
  input wire logic [7:0] tx_rs_dcc_in,
  input wire logic [7:0] tx_ms_dcc_in,
  input wire logic [7:0] tx_ms_orderwire_in,
  // results
  output logic [7:0] tx_byte_q,
  output logic tx_byte_valid_q,
  output logic tx_ais_force_q
);
  // ---------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------
  logic [7:0] rdi_ctrl_q;
  logic [7:0] op_ctrl_q;
  logic [7:0] src_a_q;
  logic [7:0] src_b_q;
  logic [7:0] k2_value_q;
  logic [7:0] cfg_q;
  logic [7:0] cpu_j0_q;
  logic [7:0] cpu_nu8_q;
  logic [7:0] cpu_nu9_q;

  wire [9:0] idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire access = psel && penable;
  wire hit_rdi = aligned && idx == tx_overhead_serial_in_pkg::IDX_RDI_CTRL;
  wire hit_op = aligned && idx == tx_overhead_serial_in_pkg::IDX_OP_CTRL;
  wire hit_src_a = aligned && idx == tx_overhead_serial_in_pkg::IDX_SRC_SEL_A;
  wire hit_src_b = aligned && idx == tx_overhead_serial_in_pkg::IDX_SRC_SEL_B;
  wire hit_k2 = aligned && idx == tx_overhead_serial_in_pkg::IDX_K2_VALUE;
  wire hit_cfg = aligned && idx == tx_overhead_serial_in_pkg::IDX_CFG;
  wire hit_j0 = aligned && idx == tx_overhead_serial_in_pkg::IDX_CPU_J0;
  wire hit_nu8 = aligned && idx == tx_overhead_serial_in_pkg::IDX_CPU_NU8;
  wire hit_nu9 = aligned && idx == tx_overhead_serial_in_pkg::IDX_CPU_NU9;
  wire hit_stat = aligned && idx == tx_overhead_serial_in_pkg::IDX_STATUS;
  wire hit_any = hit_rdi | hit_op | hit_src_a | hit_src_b | hit_k2 | hit_cfg | hit_j0 | hit_nu8 | hit_nu9
                 | hit_stat;
  wire wr = access && pwrite;
  wire [7:0] wbyte = pwdata[7:0];
  wire wr_op = wr && hit_op;

  // zero wait states; unmapped or misaligned accesses are flagged and have no effect
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdi_ctrl_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      op_ctrl_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      src_a_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      src_b_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      k2_value_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      cfg_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      cpu_j0_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      cpu_nu8_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      cpu_nu9_q <= tx_overhead_serial_in_pkg::RST_BYTE;
    end else if (wr) begin
      if (hit_rdi) rdi_ctrl_q <= wbyte & tx_overhead_serial_in_pkg::MASK_RDI_CTRL;
      if (hit_op) op_ctrl_q <= wbyte;
      if (hit_src_a) src_a_q <= wbyte;
      if (hit_src_b) src_b_q <= wbyte & tx_overhead_serial_in_pkg::MASK_SRC_SEL_B;
      if (hit_k2) k2_value_q <= wbyte;
      if (hit_cfg) cfg_q <= wbyte & tx_overhead_serial_in_pkg::MASK_CFG;
      if (hit_j0) cpu_j0_q <= wbyte;
      if (hit_nu8) cpu_nu8_q <= wbyte;
      if (hit_nu9) cpu_nu9_q <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // frame-boundary shadows
  // ---------------------------------------------------------------
  // bytes already in flight keep the settings they started the frame with
  logic [7:0] rdi_sh_q;
  logic [7:0] op_sh_q;
  logic [7:0] src_a_sh_q;
  logic [7:0] src_b_sh_q;
  logic [7:0] k2_sh_q;
  logic [7:0] cfg_sh_q;
  logic [7:0] j0_sh_q;
  logic [7:0] nu8_sh_q;
  logic [7:0] nu9_sh_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdi_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      op_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      src_a_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      src_b_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      k2_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      cfg_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      j0_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      nu8_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      nu9_sh_q <= tx_overhead_serial_in_pkg::RST_BYTE;
    end else if (frame_start) begin
      rdi_sh_q <= rdi_ctrl_q;
      op_sh_q <= op_ctrl_q;
      src_a_sh_q <= src_a_q;
      src_b_sh_q <= src_b_q;
      k2_sh_q <= k2_value_q;
      cfg_sh_q <= cfg_q;
      j0_sh_q <= cpu_j0_q;
      nu8_sh_q <= cpu_nu8_q;
      nu9_sh_q <= cpu_nu9_q;
    end
  end

  // ---------------------------------------------------------------
  // parity inversion
  // ---------------------------------------------------------------
  logic inv_b1;
  logic inv_b2;

  tx_overhead_serial_in_parity_inv u_inv_b1 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .code_wr(wbyte[tx_overhead_serial_in_pkg::OP_B1_LO +: 2]),
    .wr_stb(wr_op),
    .frame_start(frame_start),
    .invert(inv_b1)
  );

  tx_overhead_serial_in_parity_inv u_inv_b2 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .code_wr(wbyte[tx_overhead_serial_in_pkg::OP_B2_LO +: 2]),
    .wr_stb(wr_op),
    .frame_start(frame_start),
    .invert(inv_b2)
  );

  // ---------------------------------------------------------------
  // byte selection
  // ---------------------------------------------------------------
  wire regen = cfg_sh_q[tx_overhead_serial_in_pkg::CFG_REGEN];
  wire [1:0] j0_src = src_a_sh_q[tx_overhead_serial_in_pkg::SRC_J0_LO +: 2];
  wire k2_hw = !src_b_sh_q[tx_overhead_serial_in_pkg::SRCB_K2];
  wire rdi_hw = !op_sh_q[tx_overhead_serial_in_pkg::OP_RDI_SRC];

  // controls gated by K2 and RDI sourcing
  wire rdi_ctrl_live = k2_hw && rdi_hw;
  wire rdi_forced = rdi_ctrl_live && rdi_sh_q[tx_overhead_serial_in_pkg::RDI_FRC];
  wire rdi_excess = rdi_ctrl_live && rdi_sh_q[tx_overhead_serial_in_pkg::RDI_EXC_EN] && excess_ms_error_state;
  wire [2:0] rdi_bits = (rdi_forced || rdi_excess) ? tx_overhead_serial_in_pkg::RDI_CODE : tx_overhead_serial_in_pkg::RDI_NONE;

  wire [7:0] k2_internal = rdi_hw ? {k2_sh_q[7:3], rdi_bits} : k2_sh_q;
  wire [7:0] k2_byte = regen ? rx_byte : (k2_hw ? k2_internal : tx_overhead_serial_in);

  wire [7:0] m1_internal = op_sh_q[tx_overhead_serial_in_pkg::OP_REI_SRC] ? tx_overhead_serial_in_pkg::REI_ZERO : ms_err_count;
  wire [7:0] m1_byte = regen ? rx_byte : (src_a_sh_q[tx_overhead_serial_in_pkg::SRC_M1] ? tx_overhead_serial_in : m1_internal);

  wire [7:0] j0_byte = j0_src[1] ? rx_byte : (j0_src[0] ? tx_overhead_serial_in : j0_sh_q);

  wire nu_cpu = op_sh_q[tx_overhead_serial_in_pkg::OP_NU_SEL];
  wire [7:0] nu8_byte = cfg_sh_q[tx_overhead_serial_in_pkg::CFG_NU8_SER] ? tx_overhead_serial_in :
                        (nu_cpu ? nu8_sh_q : tx_overhead_serial_in_pkg::NU_DEFAULT);
  wire [7:0] nu9_byte = cfg_sh_q[tx_overhead_serial_in_pkg::CFG_NU9_SER] ? tx_overhead_serial_in :
                        (nu_cpu ? nu9_sh_q : tx_overhead_serial_in_pkg::NU_DEFAULT);

  wire [7:0] e1_byte = src_a_sh_q[tx_overhead_serial_in_pkg::SRC_E1] ? rx_byte : tx_rs_orderwire_in;
  wire [7:0] f1_byte = src_a_sh_q[tx_overhead_serial_in_pkg::SRC_F1] ? rx_byte : tx_user_channel_in;
  wire [7:0] d13_byte = src_a_sh_q[tx_overhead_serial_in_pkg::SRC_D1D3] ? rx_byte : tx_rs_dcc_in;
  wire [7:0] d412_byte = src_a_sh_q[tx_overhead_serial_in_pkg::SRC_D4D12] ? rx_byte : tx_ms_dcc_in;
  wire [7:0] e2_byte = src_a_sh_q[tx_overhead_serial_in_pkg::SRC_E2] ? rx_byte : tx_ms_orderwire_in;

  wire [7:0] b1_byte = inv_b1 ? ~parity_byte : parity_byte;
  wire [7:0] b2_byte = inv_b2 ? ~parity_byte : parity_byte;

  logic [7:0] sel_byte;
  always_comb begin
    case (tx_overhead_serial_in_pkg::tx_overhead_serial_in_slot_t'(slot_id))
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_J0: sel_byte = j0_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_E1: sel_byte = e1_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_F1: sel_byte = f1_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_D1D3: sel_byte = d13_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_D4D12: sel_byte = d412_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_E2: sel_byte = e2_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_M1: sel_byte = m1_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_K2: sel_byte = k2_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_NU8: sel_byte = nu8_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_NU9: sel_byte = nu9_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_B1: sel_byte = b1_byte;
      tx_overhead_serial_in_pkg::TX_OVERHEAD_SERIAL_IN_SLOT_B2: sel_byte = b2_byte;
      default: sel_byte = rx_byte;
    endcase
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_byte_q <= tx_overhead_serial_in_pkg::RST_BYTE;
      tx_byte_valid_q <= 1'b0;
      tx_ais_force_q <= 1'b0;
    end else begin
      tx_byte_valid_q <= slot_valid;
      if (slot_valid) begin
        tx_byte_q <= sel_byte;
      end
      if (frame_start) begin
        tx_ais_force_q <= op_ctrl_q[tx_overhead_serial_in_pkg::OP_AIS];
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0] status_byte = {4'h0, inv_b2, inv_b1, tx_ais_force_q, excess_ms_error_state};
  wire [7:0] rd_byte = ({8{hit_rdi}} & rdi_ctrl_q) | ({8{hit_op}} & op_ctrl_q) | ({8{hit_src_a}} & src_a_q)
                     | ({8{hit_src_b}} & src_b_q) | ({8{hit_k2}} & k2_value_q) | ({8{hit_cfg}} & cfg_q)
                     | ({8{hit_j0}} & cpu_j0_q) | ({8{hit_nu8}} & cpu_nu8_q) | ({8{hit_nu9}} & cpu_nu9_q)
                     | ({8{hit_stat}} & status_byte);
  assign prdata = {24'h000000, rd_byte};
endmodule

// ### tx_overhead_serial_in_pkg.sv
// constants, field layout and slot codes for the transmit section overhead control block
// Summary of operation
// - AIS-force bit set forces AIS toward the network; clear forces none.
// - With M1 internal, REI source zero sends B2 error counts, one sends zero.
// - K2 hardware: RDI source zero makes bits 2:0 internally, else all from 38H.
// - B2 invert code 0X none, 10 always, 11 for one frame.
// - B1 invert code 0X none, 10 always, 11 for one frame.
// - RDI force and excess insertion act only with K2 and RDI from hardware.
// - Excess insertion enabled sends K2 bits 2:0 as 110 while excess state is active.
// - RDI force sends K2 bits 2:0 as 110 whatever the excess state, until cleared.
// - J0 source 00 processor, 01 serial overhead input, 1X received byte.
// - E1 source zero takes orderwire input, one retransmits received E1.
// - F1 source zero takes user channel input, one retransmits received F1.
// - D1-D3 source zero takes regenerator DCC input, one retransmits received bytes.
// - D4-D12 source zero takes multiplex DCC input, one retransmits received bytes.
// - E2 source zero takes multiplex orderwire input, one retransmits received E2.
// - M1 source zero internal REI, one serial input; regenerator passes received M1.
// - K2 source zero internal, one serial input; regenerator passes received K2.
package tx_overhead_serial_in_pkg;
  localparam int unsigned DW = 8;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_RDI_CTRL = 10'h01a;
  localparam logic [9:0] IDX_OP_CTRL = 10'h030;
  localparam logic [9:0] IDX_SRC_SEL_A = 10'h060;
  localparam logic [9:0] IDX_SRC_SEL_B = 10'h061;
  localparam logic [9:0] IDX_K2_VALUE = 10'h038;
  localparam logic [9:0] IDX_CFG = 10'h070;
  localparam logic [9:0] IDX_CPU_J0 = 10'h071;
  localparam logic [9:0] IDX_CPU_NU8 = 10'h072;
  localparam logic [9:0] IDX_CPU_NU9 = 10'h073;
  localparam logic [9:0] IDX_STATUS = 10'h074;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_RDI_CTRL = 8'h06;
  localparam logic [7:0] MASK_SRC_SEL_B = 8'h02;
  localparam logic [7:0] MASK_CFG = 8'h07;
  // op ctrl fields
  localparam int unsigned OP_AIS = 7;
  localparam int unsigned OP_REI_SRC = 6;
  localparam int unsigned OP_NU_SEL = 5;
  localparam int unsigned OP_RDI_SRC = 4;
  localparam int unsigned OP_B2_LO = 2;
  localparam int unsigned OP_B1_LO = 0;
  // rdi ctrl fields
  localparam int unsigned RDI_EXC_EN = 2;
  localparam int unsigned RDI_FRC = 1;
  // source select a fields, then the source select b K2 field
  localparam int unsigned SRC_J0_LO = 6;
  localparam int unsigned SRC_E1 = 5;
  localparam int unsigned SRC_F1 = 4;
  localparam int unsigned SRC_D1D3 = 3;
  localparam int unsigned SRC_D4D12 = 2;
  localparam int unsigned SRC_E2 = 1;
  localparam int unsigned SRC_M1 = 0;
  localparam int unsigned SRCB_K2 = 1;
  // cfg fields
  localparam int unsigned CFG_REGEN = 0;
  localparam int unsigned CFG_NU8_SER = 1;
  localparam int unsigned CFG_NU9_SER = 2;
  // codes
  localparam logic [1:0] INV_FOREVER = 2'h2;
  localparam logic [1:0] INV_ONE_FRAME = 2'h3;
  localparam logic [2:0] RDI_CODE = 3'h6;
  localparam logic [2:0] RDI_NONE = 3'h0;
  localparam logic [7:0] NU_DEFAULT = 8'haa;
  localparam logic [7:0] REI_ZERO = 8'h00;
  typedef enum logic [3:0] {
    TX_OVERHEAD_SERIAL_IN_SLOT_J0, TX_OVERHEAD_SERIAL_IN_SLOT_E1, TX_OVERHEAD_SERIAL_IN_SLOT_F1, TX_OVERHEAD_SERIAL_IN_SLOT_D1D3, TX_OVERHEAD_SERIAL_IN_SLOT_D4D12, TX_OVERHEAD_SERIAL_IN_SLOT_E2,
    TX_OVERHEAD_SERIAL_IN_SLOT_M1, TX_OVERHEAD_SERIAL_IN_SLOT_K2, TX_OVERHEAD_SERIAL_IN_SLOT_NU8, TX_OVERHEAD_SERIAL_IN_SLOT_NU9, TX_OVERHEAD_SERIAL_IN_SLOT_B1, TX_OVERHEAD_SERIAL_IN_SLOT_B2
  } tx_overhead_serial_in_slot_t;
endpackage

// ### tx_overhead_serial_in_parity_inv.sv
// one parity inversion controller: continuous or single-frame
`timescale 1ns/1ps
module tx_overhead_serial_in_parity_inv (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] code_wr,
  input wire logic wr_stb,
  input wire logic frame_start,
  output logic invert
);
  logic pending_q;
  logic pending_d;
  logic once_q;
  logic forever_q;
  logic [1:0] code_q;

  // a write that lands on the boundary cycle still arms the next frame
  assign pending_d = (wr_stb && code_wr == tx_overhead_serial_in_pkg::INV_ONE_FRAME) ? 1'b1 :
                     (frame_start ? 1'b0 : pending_q);
  assign invert = once_q | forever_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pending_q <= 1'b0;
      once_q <= 1'b0;
      forever_q <= 1'b0;
      code_q <= 2'h0;
    end else begin
      pending_q <= pending_d;
      if (wr_stb) begin
        code_q <= code_wr;
      end
      if (frame_start) begin
        once_q <= pending_q;
        forever_q <= (code_q == tx_overhead_serial_in_pkg::INV_FOREVER);
      end
    end
  end
endmodule

// ### tx_overhead_serial_in_ctrl_assertions.sv
// port-level checker for the transmit section overhead control block
`timescale 1ns/1ps
module tx_overhead_serial_in_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic frame_start,
  input wire logic slot_valid,
  input wire logic [3:0] slot_id,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] tx_overhead_serial_in,
  input wire logic [7:0] tx_rs_orderwire_in,
  input wire logic [7:0] tx_rs_dcc_in,
  input wire logic [7:0] tx_ms_dcc_in,
  input wire logic [7:0] tx_ms_orderwire_in,
  input wire logic [7:0] tx_byte_q,
  input wire logic tx_byte_valid_q,
  input wire logic tx_ais_force_q
);
  // ----
  // mirror of the written settings, copied at frame boundaries
  // ----
  logic [7:0] sel_q, op_q, sel_sh_q, op_sh_q;
  wire wr_w = psel && penable && pwrite;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {sel_q, op_q, sel_sh_q, op_sh_q} <= 32'h00000000;
    end else begin
      if (wr_w && paddr == 12'h180) sel_q <= pwdata[7:0];
      if (wr_w && paddr == 12'h0c0) op_q <= pwdata[7:0];
      if (frame_start) {sel_sh_q, op_sh_q} <= {sel_q, op_q};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_slot_answer: assert property (slot_valid |=> tx_byte_valid_q)
    else $error("slot not answered in the next cycle");
  a_no_spurious: assert property (!slot_valid |=> !tx_byte_valid_q && $stable(tx_byte_q))
    else $error("output byte moved without a slot");
  a_ais_frame: assert property (tx_ais_force_q == op_sh_q[7])
    else $error("ais force differs from frame setting");
  a_j0_source: assert property (slot_valid && slot_id == 4'h0 && sel_sh_q[7:6] != 2'h0 |=>
    tx_byte_q == ($past(sel_sh_q[7]) ? $past(rx_byte) : $past(tx_overhead_serial_in)))
    else $error("j0 source wrong");
  a_e1_source: assert property (slot_valid && slot_id == 4'h1 |-> ##1
    tx_byte_q == ($past(sel_sh_q[5]) ? $past(rx_byte) : $past(tx_rs_orderwire_in)))
    else $error("e1 source wrong");
  a_rs_dcc: assert property (slot_valid && slot_id == 4'h3 |=>
    tx_byte_q == ($past(sel_sh_q[3]) ? $past(rx_byte) : $past(tx_rs_dcc_in)))
    else $error("d1-d3 source wrong");
  a_ms_dcc: assert property (slot_valid && slot_id == 4'h4 ##1 tx_byte_valid_q |->
    tx_byte_q == ($past(sel_sh_q[2]) ? $past(rx_byte) : $past(tx_ms_dcc_in)))
    else $error("d4-d12 source wrong");
  a_e2_source: assert property (slot_valid && slot_id == 4'h5 |=>
    tx_byte_q == ($past(sel_sh_q[1]) ? $past(rx_byte) : $past(tx_ms_orderwire_in)))
    else $error("e2 source wrong");
endmodule

// ### tx_overhead_serial_in_line_model.sv
// outgoing line side: frame and slot timing, captures each sent byte
`timescale 1ns/1ps
module tx_overhead_serial_in_line_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic go_frame,
  input wire logic go_slot,
  input wire logic [3:0] go_id,
  input wire logic [7:0] tx_byte_q,
  input wire logic tx_byte_valid_q,
  output logic frame_start,
  output logic slot_valid,
  output logic [3:0] slot_id,
  output logic [7:0] got_byte
);
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {frame_start, slot_valid, slot_id, got_byte} <= 14'h0000;
    end else begin
      frame_start <= go_frame;
      slot_valid <= go_slot;
      // idle id keeps moving so a stale code never passes for a live slot
      slot_id <= go_slot ? go_id : ~slot_id;
      if (tx_byte_valid_q) got_byte <= tx_byte_q;
    end
  end
endmodule

// ### tx_section_overhead_control_bench.sv
// self-checking bench for the transmit section overhead control block
`timescale 1ns/1ps
module tx_section_overhead_control_bench;
  logic clk_sys, rstn, psel, penable, pwrite, go_frame, go_slot, excess_st;
  logic pready, pslverr, frame_start, slot_valid, tx_byte_valid_q, tx_ais_force_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] go_id, slot_id;
  logic [7:0] rx_byte, pb, ms_err, tx_byte_q, got_byte;
  logic [7:0] ser_in [6];
  int miscompares = 0;
  int n_compared = 0;
  tx_overhead_serial_in_ctrl i_tx_overhead_serial_in_ctrl (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .slot_valid(slot_valid), .slot_id(slot_id), .rx_byte(rx_byte),
    .parity_byte(pb), .ms_err_count(ms_err), .excess_ms_error_state(excess_st),
    .tx_overhead_serial_in(ser_in[0]), .tx_rs_orderwire_in(ser_in[1]), .tx_user_channel_in(ser_in[2]),
    .tx_rs_dcc_in(ser_in[3]), .tx_ms_dcc_in(ser_in[4]), .tx_ms_orderwire_in(ser_in[5]),
    .tx_byte_q(tx_byte_q), .tx_byte_valid_q(tx_byte_valid_q), .tx_ais_force_q(tx_ais_force_q));
  tx_overhead_serial_in_line_model i_tx_overhead_serial_in_line_model (.clk_sys(clk_sys), .rstn(rstn), .go_frame(go_frame), .go_slot(go_slot),
    .go_id(go_id), .tx_byte_q(tx_byte_q), .tx_byte_valid_q(tx_byte_valid_q), .frame_start(frame_start),
    .slot_valid(slot_valid), .slot_id(slot_id), .got_byte(got_byte));
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; byte address is four times the index
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic frame();
    @(posedge clk_sys);
    go_frame <= 1'b1;
    @(posedge clk_sys);
    go_frame <= 1'b0;
    @(posedge clk_sys);
  endtask
  // model answers one edge late, the block one more, capture one more
  task automatic slot(input logic [3:0] id, input logic [7:0] exp);
    @(posedge clk_sys);
    go_slot <= 1'b1;
    go_id <= id;
    @(posedge clk_sys);
    go_slot <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({24'h0, got_byte}, {24'h0, exp});
  endtask
  task automatic t_regs();
    rdc(10'h01a, 32'h0, 1'b0);
    rdc(10'h030, 32'h0, 1'b0);
    rdc(10'h060, 32'h0, 1'b0);
    wr(10'h01a, 8'hff);
    rdc(10'h01a, 32'h6, 1'b0);
    wr(10'h01a, 8'h00);
    rdc(10'h3ff, 32'h0, 1'b1);
    $display("register test done");
  endtask
  task automatic t_src();
    wr(10'h060, 8'h40);
    frame();
    for (int i = 0; i < 6; i++) slot(4'(i), ser_in[i]);
    // received j0 is sent back with J0 source 1X, whatever the regenerator setting
    wr(10'h070, 8'h01);
    wr(10'h060, 8'hbe);
    frame();
    for (int i = 0; i < 6; i++) slot(4'(i), rx_byte);
    wr(10'h070, 8'h00);
    wr(10'h060, 8'h00);
    wr(10'h071, 8'h5e);
    slot(4'h2, rx_byte);
    frame();
    slot(4'h0, 8'h5e);
    slot(4'h2, ser_in[2]);
    $display("source test done");
  endtask
  task automatic t_misc();
    slot(4'h6, ms_err);
    slot(4'h8, 8'haa);
    wr(10'h030, 8'hc0);
    frame();
    slot(4'h6, 8'h00);
    chk({31'h0, tx_ais_force_q}, 32'h1);
    rdc(10'h074, 32'h2, 1'b0);
    wr(10'h060, 8'h01);
    wr(10'h072, 8'h3d);
    wr(10'h030, 8'h20);
    frame();
    slot(4'h6, ser_in[0]);
    slot(4'h8, 8'h3d);
    chk({31'h0, tx_ais_force_q}, 32'h0);
    wr(10'h073, 8'h4b);
    wr(10'h070, 8'h06);
    frame();
    slot(4'h8, ser_in[0]);
    slot(4'h9, ser_in[0]);
    wr(10'h070, 8'h00);
    frame();
    slot(4'h9, 8'h4b);
    wr(10'h060, 8'h00);
    $display("misc test done");
  endtask
  task automatic t_k2();
    wr(10'h038, 8'hf5);
    frame();
    slot(4'h7, 8'hf0);
    excess_st <= 1'b1;
    rdc(10'h074, 32'h1, 1'b0);
    slot(4'h7, 8'hf0);
    wr(10'h01a, 8'h04);
    frame();
    slot(4'h7, 8'hf6);
    excess_st <= 1'b0;
    slot(4'h7, 8'hf0);
    wr(10'h01a, 8'h02);
    frame();
    slot(4'h7, 8'hf6);
    wr(10'h030, 8'h10);
    frame();
    slot(4'h7, 8'hf5);
    wr(10'h030, 8'h00);
    wr(10'h061, 8'h02);
    frame();
    slot(4'h7, ser_in[0]);
    wr(10'h070, 8'h01);
    frame();
    slot(4'h7, rx_byte);
    slot(4'h6, rx_byte);
    wr(10'h070, 8'h00);
    $display("k2 test done");
  endtask
  task automatic t_par();
    for (int f = 0; f < 2; f++) begin
      wr(10'h030, 8'h02 << (2 * f));
      frame();
      frame();
      slot(4'(10 + f), ~pb);
      rdc(10'h074, 32'h4 << f, 1'b0);
      wr(10'h030, 8'h03 << (2 * f));
      frame();
      slot(4'(10 + f), ~pb);
      frame();
      slot(4'(10 + f), pb);
      wr(10'h030, 8'h01 << (2 * f));
      frame();
      slot(4'(10 + f), pb);
    end
    $display("parity test done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    int cyc;
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc == 6000) begin
        miscompares++;
        stop_test();
      end
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, go_frame, go_slot, excess_st} = 7'h00;
    {paddr, pwdata, go_id} = 48'h0;
    {rx_byte, pb, ms_err} = 24'h3c5a21;
    ser_in = '{8'h71, 8'h82, 8'h93, 8'ha4, 8'hb5, 8'hc6};
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_src();
    t_misc();
    t_k2();
    t_par();
    stop_test();
  end
endmodule
bind tx_overhead_serial_in_ctrl tx_overhead_serial_in_ctrl_assertions i_tx_overhead_serial_in_ctrl_assertions (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .frame_start(frame_start),
  .slot_valid(slot_valid), .slot_id(slot_id), .rx_byte(rx_byte), .tx_overhead_serial_in(tx_overhead_serial_in),
  .tx_rs_orderwire_in(tx_rs_orderwire_in), .tx_rs_dcc_in(tx_rs_dcc_in), .tx_ms_dcc_in(tx_ms_dcc_in),
  .tx_ms_orderwire_in(tx_ms_orderwire_in), .tx_byte_q(tx_byte_q), .tx_byte_valid_q(tx_byte_valid_q),
  .tx_ais_force_q(tx_ais_force_q));
